// ---- core/eeprom_target_pkg.sv ----
// Operation
// - Target only; controller starts transfers, drives clock.
// - Start is data falling while clock high.
// - Outside programming, ignore everything until start.
// - Stop is data rising while clock high.
// - Stop ending a write launches programming.
// - Stop after not-acknowledged read returns to standby.
// - Select byte: type, three select bits, direction.
// - Compare select bits with strapped select inputs.
// - Larger densities use select bits as address.
// - Sender releases; receiver pulls low in ninth slot.
// - Device acknowledges controller bytes on writes.
// - Sample data on rising clock edge.
// - Write-protect high blocks all array writes; code samples it only from start until the first data byte.
// - Protected: acknowledge select and address, not data.
// - During power-on reset, answer nothing.
// - Data line is open drain only.
// - Array is 8-bit bytes, density-dependent count.
// - Byte writes and page writes up to sixteen.
// - Select byte follows start, then acknowledge slot.
// - Direction bit one reads, zero writes.
// - Mismatched select: no acknowledge, go standby.
// - Ignore the bus while programming.
// - Only stop right after write acknowledge programs.
package eeprom_target_pkg;
   // Device type code; this value is arbitrary.
   localparam logic [3:0] DEV_TYPE_CODE = 4'h6;
   // Number of select bits reused as upper address bits (0 to 3).
   localparam int UPPER_BITS = 1;
   localparam int ADDR_W = 8 + UPPER_BITS;
   localparam int MEM_BYTES = 1 << ADDR_W;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_W = 4;
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_TIME_NS = 5000000;
   localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 18;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;

   typedef struct packed {
      logic select_strap_high;
      logic select_strap_mid;
      logic select_strap_low;
   } strap_s;

   typedef enum logic [1:0] {
      KIND_SELECT,
      KIND_WORD_ADDR,
      KIND_DATA
   } byte_kind_e;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_MACK
   } phase_e;
endpackage : eeprom_target_pkg

// ---- core/eeprom_target.sv ----
`timescale 1ns/1ps
`default_nettype none
module eeprom_target
   import eeprom_target_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire strap_s straps,
   input wire logic write_protect_input,
   output logic prog_busy
);

   // ------------------------------------------------------------
   // Pin synchronisers and bus condition detection
   // ------------------------------------------------------------
   logic scl_s1_ff, scl_s2_ff, scl_d_ff;
   logic sda_s1_ff, sda_s2_ff, sda_d_ff;
   logic wp_s1_ff, wp_s2_ff;
   strap_s strap_s1_ff, strap_s2_ff;

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         wp_s1_ff <= 1'b0;
         wp_s2_ff <= 1'b0;
         strap_s1_ff <= '0;
         strap_s2_ff <= '0;
      end else begin
         scl_s1_ff <= scl_in;
         scl_s2_ff <= scl_s1_ff;
         scl_d_ff <= scl_s2_ff;
         sda_s1_ff <= sda_in;
         sda_s2_ff <= sda_s1_ff;
         sda_d_ff <= sda_s2_ff;
         wp_s1_ff <= write_protect_input;
         wp_s2_ff <= wp_s1_ff;
         strap_s1_ff <= straps;
         strap_s2_ff <= strap_s1_ff;
      end
   end

   logic busy_ff;
   logic start_ev, stop_ev, scl_rise, scl_fall;
   // Conditions need the clock high in both samples, so a data edge
   // that coincides with a clock edge is treated as ordinary data.
   assign start_ev = scl_s2_ff && scl_d_ff && sda_d_ff && !sda_s2_ff && !busy_ff;
   assign stop_ev = scl_s2_ff && scl_d_ff && !sda_d_ff && sda_s2_ff && !busy_ff;
   assign scl_rise = scl_s2_ff && !scl_d_ff;
   assign scl_fall = !scl_s2_ff && scl_d_ff;

   function automatic logic sel_match(input logic [7:0] sel, input strap_s st);
      logic [2:0] pins;
      logic ok;
      pins = st;
      ok = (sel[7:4] == DEV_TYPE_CODE);
      for (int i = UPPER_BITS; i < 3; i++) begin
         if (sel[i+1] != pins[i]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : sel_match

   // ------------------------------------------------------------
   // Protocol engine
   // ------------------------------------------------------------
   phase_e phase_ff;
   byte_kind_e kind_ff;
   logic [7:0] shreg_ff, tx_ff;
   logic [3:0] bit_cnt_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic rw_ff, wp_lat_ff, wr_armed_ff, acked_ff, mack_ff, sda_oe_ff;
   logic [7:0] mem_ff [MEM_BYTES];

   logic byte_done, data_take;
   assign byte_done = (phase_ff == ST_RX) && scl_fall && (bit_cnt_ff == BITS_PER_BYTE);
   assign data_take = byte_done && (kind_ff == KIND_DATA) && !wp_lat_ff;

   always_ff @(posedge clk) begin
      if (reset || busy_ff) begin
         phase_ff <= ST_IDLE;
         sda_oe_ff <= 1'b0;
         kind_ff <= KIND_SELECT;
         bit_cnt_ff <= '0;
         shreg_ff <= '0;
         tx_ff <= '0;
         rw_ff <= 1'b0;
         wp_lat_ff <= 1'b0;
         wr_armed_ff <= 1'b0;
         acked_ff <= 1'b0;
         mack_ff <= 1'b0;
         if (reset) begin
            addr_ff <= '0;
         end
      end else if (start_ev) begin
         phase_ff <= ST_RX;
         kind_ff <= KIND_SELECT;
         bit_cnt_ff <= '0;
         sda_oe_ff <= 1'b0;
         wr_armed_ff <= 1'b0;
         wp_lat_ff <= wp_s2_ff;
      end else if (stop_ev) begin
         phase_ff <= ST_IDLE;
         sda_oe_ff <= 1'b0;
         wr_armed_ff <= 1'b0;
      end else begin
         if (kind_ff != KIND_DATA && wp_s2_ff) begin
            wp_lat_ff <= 1'b1;
         end
         case (phase_ff)
            ST_RX: begin
               if (scl_rise) begin
                  shreg_ff <= {shreg_ff[6:0], sda_s2_ff};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end else if (scl_fall && bit_cnt_ff != '0) begin
                  wr_armed_ff <= 1'b0;
               end
               if (byte_done) begin
                  case (kind_ff)
                     KIND_SELECT: begin
                        if (sel_match(shreg_ff, strap_s2_ff)) begin
                           phase_ff <= ST_ACK;
                           sda_oe_ff <= 1'b1;
                           acked_ff <= 1'b1;
                           rw_ff <= shreg_ff[0];
                           for (int i = 0; i < UPPER_BITS; i++) begin
                              addr_ff[8+i] <= shreg_ff[i+1];
                           end
                        end else begin
                           phase_ff <= ST_IDLE;
                        end
                     end
                     KIND_WORD_ADDR: begin
                        phase_ff <= ST_ACK;
                        sda_oe_ff <= 1'b1;
                        acked_ff <= 1'b1;
                        addr_ff[7:0] <= shreg_ff;
                     end
                     default: begin
                        phase_ff <= ST_ACK;
                        sda_oe_ff <= !wp_lat_ff;
                        acked_ff <= !wp_lat_ff;
                        if (!wp_lat_ff) begin
                           addr_ff[PAGE_W-1:0] <= addr_ff[PAGE_W-1:0] + 4'h1;
                        end
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  sda_oe_ff <= 1'b0;
                  bit_cnt_ff <= '0;
                  wr_armed_ff <= acked_ff && (kind_ff == KIND_DATA);
                  if (kind_ff == KIND_SELECT && rw_ff) begin
                     phase_ff <= ST_TX;
                     sda_oe_ff <= !mem_ff[addr_ff][7];
                     tx_ff <= {mem_ff[addr_ff][6:0], 1'b0};
                     addr_ff <= addr_ff + 1'b1;
                  end else begin
                     phase_ff <= ST_RX;
                     kind_ff <= (kind_ff == KIND_SELECT) ? KIND_WORD_ADDR : KIND_DATA;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  if (bit_cnt_ff == LAST_TX_BIT) begin
                     phase_ff <= ST_MACK;
                     sda_oe_ff <= 1'b0;
                  end else begin
                     sda_oe_ff <= !tx_ff[7];
                     tx_ff <= {tx_ff[6:0], 1'b0};
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  mack_ff <= !sda_s2_ff;
               end
               if (scl_fall) begin
                  bit_cnt_ff <= '0;
                  if (mack_ff) begin
                     phase_ff <= ST_TX;
                     sda_oe_ff <= !mem_ff[addr_ff][7];
                     tx_ff <= {mem_ff[addr_ff][6:0], 1'b0};
                     addr_ff <= addr_ff + 1'b1;
                  end else begin
                     phase_ff <= ST_IDLE;
                  end
               end
            end
            default: begin
               sda_oe_ff <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Page buffer, self-timed programming and array
   // ------------------------------------------------------------
   logic [TIMER_W-1:0] timer_ff;
   logic [7:0] pg_data_ff [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pg_valid_ff;
   logic [ADDR_W-1:PAGE_W] pg_base_ff;
   logic launch, prog_done;
   assign launch = stop_ev && wr_armed_ff;
   assign prog_done = busy_ff && (timer_ff == TIMER_W'(PROG_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (reset) begin
         busy_ff <= 1'b0;
         timer_ff <= '0;
      end else if (launch) begin
         busy_ff <= 1'b1;
         timer_ff <= '0;
      end else if (prog_done) begin
         busy_ff <= 1'b0;
      end else if (busy_ff) begin
         timer_ff <= timer_ff + 1'b1;
      end
   end

   // Unprogrammed latches are dropped on a new start or a stop that does
   // not launch, so an aborted write never reaches the array.
   always_ff @(posedge clk) begin
      if (reset) begin
         pg_valid_ff <= '0;
         pg_base_ff <= '0;
      end else if (data_take) begin
         pg_data_ff[addr_ff[PAGE_W-1:0]] <= shreg_ff;
         pg_valid_ff[addr_ff[PAGE_W-1:0]] <= 1'b1;
         pg_base_ff <= addr_ff[ADDR_W-1:PAGE_W];
      end else if (prog_done || ((start_ev || stop_ev) && !launch)) begin
         pg_valid_ff <= '0;
      end
   end

   always_ff @(posedge clk) begin
      if (prog_done) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (pg_valid_ff[i]) begin
               mem_ff[{pg_base_ff, PAGE_W'(i)}] <= pg_data_ff[i];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   assign sda_oe = sda_oe_ff;
   assign prog_busy = busy_ff;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence sel_done_s;
      byte_done && (kind_ff == KIND_SELECT);
   endsequence

   sequence data_done_s;
      byte_done && (kind_ff == KIND_DATA);
   endsequence

   busy_quiet_a: assert property (@(posedge clk) disable iff (reset)
      busy_ff |-> !sda_oe_ff && phase_ff == ST_IDLE)
      else $error("device drives bus while programming");
   start_seen_a: assert property (@(posedge clk) disable iff (reset)
      start_ev |=> phase_ff == ST_RX && bit_cnt_ff == 4'h0 && kind_ff == KIND_SELECT)
      else $error("start not taken");
   stop_ends_a: assert property (@(posedge clk) disable iff (reset)
      stop_ev |=> phase_ff == ST_IDLE && !sda_oe_ff)
      else $error("stop did not end communication");
   write_launch_a: assert property (@(posedge clk) disable iff (reset)
      stop_ev && wr_armed_ff |=> busy_ff [*2])
      else $error("programming not launched");
   no_launch_a: assert property (@(posedge clk) disable iff (reset)
      !busy_ff && !launch |=> !busy_ff)
      else $error("programming started without armed stop");
   mismatch_nack_a: assert property (@(posedge clk) disable iff (reset)
      sel_done_s ##0 !sel_match(shreg_ff, strap_s2_ff) |=> phase_ff == ST_IDLE && !sda_oe_ff)
      else $error("mismatched select acknowledged");
   protect_nack_a: assert property (@(posedge clk) disable iff (reset)
      data_done_s ##0 wp_lat_ff |=> phase_ff == ST_ACK && !sda_oe_ff)
      else $error("protected data byte acknowledged");
   addr_ack_a: assert property (@(posedge clk) disable iff (reset)
      byte_done && kind_ff == KIND_WORD_ADDR |=> sda_oe_ff)
      else $error("address byte not acknowledged");
   low_change_a: assert property (@(posedge clk) disable iff (reset)
      $rose(sda_oe_ff) |-> !scl_d_ff)
      else $error("data line pulled while clock high");
   open_drain_a: assert property (@(posedge clk) disable iff (reset)
      sda_out == 1'b0)
      else $error("data line driven high");
   por_idle_a: assert property (@(posedge clk)
      reset |=> !sda_oe_ff && !busy_ff && phase_ff == ST_IDLE)
      else $error("activity during power-on reset");
   prog_time_a: assert property (@(posedge clk) disable iff (reset)
      busy_ff && timer_ff != TIMER_W'(PROG_CYCLES - 1) |=> busy_ff)
      else $error("programming cycle ended early");

endmodule : eeprom_target
`default_nettype wire

// ---- test/i2c_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   // On the data line the model only ever pulls low or releases; the pull-up gives the high level.
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Every change lands 1 ns after a rising edge of the system clock.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // Data falls while the clock is high; works from idle and as a repeated start.
   task automatic start_cond();
      sda_low = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(8);
      sda_low = 1'b1;
      tick(8);
      scl = 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      tick(4);
      sda_low = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(8);
      sda_low = 1'b0;
      tick(8);
   endtask : stop_cond

   // Data changes mid low phase and is looked at mid high phase.
   task automatic bit_slot(input logic b, output logic seen);
      tick(4);
      sda_low = ~b;
      tick(4);
      scl = 1'b1;
      tick(4);
      seen = sda_line;
      tick(4);
      scl = 1'b0;
   endtask : bit_slot

   task automatic send_byte(input logic [7:0] b, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(b[i], s);
      end
      bit_slot(1'b1, s);
      acked = ~s;
   endtask : send_byte

   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, d[i]);
      end
      bit_slot(~ack, s);
   endtask : recv_byte
endmodule : i2c_ctrl_model
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
   import eeprom_target_pkg::*;
();
   // Long enough that a full select byte fits inside one programming cycle.
   localparam int PROG_N = 400;
   logic clk, reset, scl, sda_low, sda_line, sda_out, sda_oe, wp, prog_busy, prev_oe, a;
   logic [7:0] d0, d1;
   strap_s straps;
   int num_errors = 0;
   int checks_done = 0;
   assign sda_line = ~(sda_low | sda_oe);
   eeprom_target #(.PROG_CYCLES(PROG_N)) dut_u (.clk(clk), .reset(reset), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .straps(straps),
      .write_protect_input(wp), .prog_busy(prog_busy));
   i2c_ctrl_model ctrl_u (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic report_and_stop();
      if (num_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   // The acknowledge may only move while the serial clock is low.
   always @(posedge clk) begin
      if (!reset && scl && sda_oe !== prev_oe) check(1'b0, "data line moved with clock high");
      if (sda_oe === 1'b1) check(sda_out === 1'b0, "data line driven high");
      prev_oe <= sda_oe;
   end

   function automatic logic [7:0] sel(input logic a8, input logic rw);
      return {DEV_TYPE_CODE, straps.select_strap_high, straps.select_strap_mid, a8, rw};
   endfunction : sel

   // Starts a write and sends the select byte and the low address byte.
   task automatic addr_phase(input logic [8:0] ad);
      ctrl_u.start_cond();
      ctrl_u.send_byte(sel(ad[8], 1'b0), a);
      check(a === 1'b1, "write select not acknowledged");
      ctrl_u.send_byte(ad[7:0], a);
      check(a === 1'b1, "address not acknowledged");
   endtask : addr_phase

   task automatic wait_idle();
      for (int i = 0; i <= PROG_N + 50; i++) begin
         if (prog_busy === 1'b0) return;
         ctrl_u.tick(1);
      end
      check(1'b0, "programming never finished");
      report_and_stop();
   endtask : wait_idle

   task automatic sc_reset_mute();
      reset = 1'b1;
      ctrl_u.start_cond();
      ctrl_u.send_byte(sel(1'b0, 1'b0), a);
      check(a === 1'b0, "answered during reset");
      ctrl_u.stop_cond();
      reset = 1'b0;
      ctrl_u.tick(4);
   endtask : sc_reset_mute

   task automatic sc_page_write(input logic [8:0] ad, input logic [7:0] v0, v1);
      addr_phase(ad);
      ctrl_u.send_byte(v0, a);
      check(a === 1'b1, "first data byte not acknowledged");
      ctrl_u.send_byte(v1, a);
      check(a === 1'b1, "second data byte not acknowledged");
      ctrl_u.stop_cond();
      check(prog_busy === 1'b1, "stop after write did not program");
      ctrl_u.start_cond();
      ctrl_u.send_byte(sel(ad[8], 1'b0), a);
      check(a === 1'b0, "answered while programming");
      ctrl_u.stop_cond();
      wait_idle();
   endtask : sc_page_write

   task automatic sc_read(input logic [8:0] ad, input logic [7:0] v0, v1);
      addr_phase(ad);
      ctrl_u.start_cond();
      ctrl_u.send_byte(sel(ad[8], 1'b1), a);
      check(a === 1'b1, "read select not acknowledged");
      ctrl_u.recv_byte(1'b1, d0);
      check(d0 === v0, "first read byte wrong");
      ctrl_u.recv_byte(1'b0, d1);
      check(d1 === v1, "sequential read byte wrong");
      ctrl_u.stop_cond();
      check(prog_busy === 1'b0, "read stop started programming");
   endtask : sc_read

   task automatic sc_protect(input logic [8:0] ad);
      wp = 1'b1;
      addr_phase(ad);
      ctrl_u.send_byte(8'h00, a);
      check(a === 1'b0, "protected data byte acknowledged");
      ctrl_u.stop_cond();
      check(prog_busy === 1'b0, "protected write programmed");
      wp = 1'b0;
   endtask : sc_protect

   task automatic sc_early_stop(input logic [8:0] ad);
      addr_phase(ad);
      ctrl_u.stop_cond();
      check(prog_busy === 1'b0, "stop after address programmed");
   endtask : sc_early_stop

   task automatic sc_mismatch();
      ctrl_u.start_cond();
      ctrl_u.send_byte(sel(1'b0, 1'b0) ^ 8'h04, a);
      check(a === 1'b0, "wrong strap bits acknowledged");
      ctrl_u.send_byte(sel(1'b0, 1'b0), a);
      check(a === 1'b0, "answered without a new start");
      ctrl_u.start_cond();
      ctrl_u.send_byte(sel(1'b0, 1'b0) ^ 8'h80, a);
      check(a === 1'b0, "wrong type code acknowledged");
      ctrl_u.stop_cond();
   endtask : sc_mismatch

   initial begin
      reset = 1'b1;
      wp = 1'b0;
      straps = 3'h5;
      repeat (5) @(posedge clk);
      #1;
      reset = 1'b0;
      ctrl_u.tick(4);
      sc_reset_mute();
      sc_page_write(9'h1f3, 8'h5a, 8'ha5);
      sc_page_write(9'h0f3, 8'h3c, 8'hc3);
      sc_read(9'h1f3, 8'h5a, 8'ha5);
      sc_protect(9'h1f3);
      sc_read(9'h1f3, 8'h5a, 8'ha5);
      sc_early_stop(9'h1f3);
      sc_read(9'h0f3, 8'h3c, 8'hc3);
      sc_mismatch();
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
